// ==== design/image_port.sv ====
// Image output port: reference pins, polarities, limiting, swap, arbitration, FIFO flags
`timescale 1ns/1ps
`default_nettype none
`include "image_port_map.svh"
module image_port #(
   parameter int DEPTH = `IP_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Subaddress register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   // Scaler timing, same clock
   input wire logic line_gate_i,
   input wire logic scaler_window_i,
   input wire logic in_href_i,
   input wire logic vert_gate_i,
   input wire logic in_vref_i,
   input wire logic field_id_i,
   input wire logic task_flag_i,
   // Video stream; vid_code_i marks timing code words
   input wire logic vid_valid_i,
   output logic vid_ready_o,
   input wire logic [31:0] vid_data_i,
   input wire logic vid_code_i,
   // Sliced text stream
   input wire logic text_valid_i,
   output logic text_ready_o,
   input wire logic [31:0] text_data_i,
   // Port clock from the receiving controller, asynchronous
   input wire logic port_clk_i,
   // Image port pins
   output logic [31:0] port_data_o,
   output logic data_qualifier_out_o,
   output logic horiz_ref_out_o,
   output logic vert_ref_out_o,
   output logic gp_out_a_o,
   output logic gp_out_b_o
);
   localparam int CW = $clog2(DEPTH+1);
   localparam int FW = 33;

   initial begin
      if (DEPTH < `IP_AF_LVL3) begin
         $error("image_port: DEPTH must hold at least 32 double words");
      end
   end

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   function automatic logic [7:0] clip_byte(input logic [7:0] b, input logic narrow);
      logic [7:0] lo;
      logic [7:0] hi;
      lo = narrow ? `IP_LIM_LO_NARROW : `IP_LIM_LO_WIDE;
      hi = narrow ? `IP_LIM_HI_NARROW : `IP_LIM_HI_WIDE;
      if (b < lo) begin
         clip_byte = lo;
      end else if (b > hi) begin
         clip_byte = hi;
      end else begin
         clip_byte = b;
      end
   endfunction

   function automatic logic [31:0] swap_word(input logic [31:0] w, input logic [1:0] mode);
      case (mode)
         2'b00: swap_word = w;
         2'b01: swap_word = {w[23:16], w[31:24], w[7:0], w[15:8]};
         2'b10: swap_word = {w[15:0], w[31:16]};
         2'b11: swap_word = {w[7:0], w[15:8], w[23:16], w[31:24]};
         default: swap_word = w;
      endcase
   endfunction

   function automatic logic gp_pick(input logic [2:0] sel, input logic [7:0] src);
      gp_pick = src[sel];
   endfunction

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] ref_sel_reg;
   logic [7:0] swap_pol_reg;
   logic [7:0] fifo_arb_reg;
   logic [7:0] rdata_reg;

   wire sel_ref_w = (reg_addr_i == `IP_REF_SEL_ADDR);
   wire sel_swap_w = (reg_addr_i == `IP_SWAP_POL_ADDR);
   wire sel_fifo_w = (reg_addr_i == `IP_FIFO_ARB_ADDR);
   wire [7:0] rd_mux_w = sel_ref_w ? ref_sel_reg :
                         sel_swap_w ? swap_pol_reg :
                         sel_fifo_w ? fifo_arb_reg : `IP_UNMAPPED_RD;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_sel_reg <= `IP_REF_SEL_RST;
         swap_pol_reg <= `IP_SWAP_POL_RST;
         fifo_arb_reg <= `IP_FIFO_ARB_RST;
         rdata_reg <= `IP_UNMAPPED_RD;
      end else begin
         if (reg_we_i && sel_ref_w) begin
            ref_sel_reg <= reg_wdata_i;
         end
         if (reg_we_i && sel_swap_w) begin
            swap_pol_reg <= reg_wdata_i;
         end
         if (reg_we_i && sel_fifo_w) begin
            fifo_arb_reg <= reg_wdata_i;
         end
         if (reg_re_i) begin
            rdata_reg <= rd_mux_w;
         end
      end
   end
   assign reg_rdata_o = rdata_reg;

   // Field decode
   wire [1:0] hsel_w = ref_sel_reg[`IP_HSEL_MSB:`IP_HSEL_LSB];
   wire [1:0] vsel_w = ref_sel_reg[`IP_VSEL_MSB:`IP_VSEL_LSB];
   wire [2:0] gpa_sel_w = {fifo_arb_reg[`IP_GPA_EXT_BIT],
                           ref_sel_reg[`IP_GPA_SEL_MSB:`IP_GPA_SEL_LSB]};
   wire [2:0] gpb_sel_w = {fifo_arb_reg[`IP_GPB_EXT_BIT],
                           ref_sel_reg[`IP_GPB_SEL_MSB:`IP_GPB_SEL_LSB]};
   wire [1:0] swap_w = swap_pol_reg[`IP_SWAP_MSB:`IP_SWAP_LSB];
   wire narrow_w = swap_pol_reg[`IP_LIMIT_BIT];
   wire [1:0] arb_w = fifo_arb_reg[`IP_ARB_MSB:`IP_ARB_LSB];
   wire [1:0] empty_th_w = fifo_arb_reg[`IP_EMPTY_TH_MSB:`IP_EMPTY_TH_LSB];
   wire [1:0] full_th_w = fifo_arb_reg[`IP_FULL_TH_MSB:`IP_FULL_TH_LSB];

   // ---------------------------------------------------------------
   // Arbitration and word shaping
   // ---------------------------------------------------------------
   wire text_en_w = (arb_w == image_port_pkg::ARB_TEXT) ||
                    (arb_w == image_port_pkg::ARB_BOTH);
   wire vid_en_w = (arb_w == image_port_pkg::ARB_VIDEO) ||
                   (arb_w == image_port_pkg::ARB_BOTH);
   wire take_text_w = text_valid_i && text_en_w;
   wire take_vid_w = vid_valid_i && vid_en_w && !take_text_w;
   wire fifo_wr_ready_w;

   // Timing codes carry 00/FF so they bypass the clipper
   wire [31:0] vid_clip_w = vid_code_i ? vid_data_i :
                            {clip_byte(vid_data_i[31:24], narrow_w),
                             clip_byte(vid_data_i[23:16], narrow_w),
                             clip_byte(vid_data_i[15:8], narrow_w),
                             clip_byte(vid_data_i[7:0], narrow_w)};
   wire [31:0] pick_w = take_text_w ? text_data_i : vid_clip_w;
   wire [FW-1:0] push_word_w = {take_text_w, swap_word(pick_w, swap_w)};
   wire push_valid_w = take_text_w || take_vid_w;

   // Refused sources are stalled rather than dropped
   assign text_ready_o = take_text_w && fifo_wr_ready_w;
   assign vid_ready_o = take_vid_w && fifo_wr_ready_w;

   // ---------------------------------------------------------------
   // Port clock crossing and output FIFO
   // ---------------------------------------------------------------
   logic pclk_meta_reg;
   logic pclk_sync_reg;
   logic pclk_prev_reg;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pclk_meta_reg <= 1'b0;
         pclk_sync_reg <= 1'b0;
         pclk_prev_reg <= 1'b0;
      end else begin
         pclk_meta_reg <= port_clk_i;
         pclk_sync_reg <= pclk_meta_reg;
         pclk_prev_reg <= pclk_sync_reg;
      end
   end
   wire pclk_rise_w = pclk_sync_reg && !pclk_prev_reg;

   wire fifo_rd_valid_w;
   wire [FW-1:0] fifo_rd_data_w;
   wire [CW-1:0] count_w;
   wire pop_w = pclk_rise_w && fifo_rd_valid_w &&
                (arb_w != image_port_pkg::ARB_INHIBIT);

   word_fifo #(
      .WIDTH(FW),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_valid_i(push_valid_w),
      .wr_ready_o(fifo_wr_ready_w),
      .wr_data_i(push_word_w),
      .rd_valid_o(fifo_rd_valid_w),
      .rd_ready_i(pop_w),
      .rd_data_o(fifo_rd_data_w),
      .count_o(count_w)
   );
   assign port_data_o = fifo_rd_data_w[31:0];

   // ---------------------------------------------------------------
   // FIFO flags, whole double words
   // ---------------------------------------------------------------
   wire near_empty_w = (empty_th_w == 2'b00) ? (count_w < CW'(`IP_AE_LVL0)) :
                       (empty_th_w == 2'b01) ? (count_w < CW'(`IP_AE_LVL1)) :
                       (empty_th_w == 2'b10) ? (count_w < CW'(`IP_AE_LVL2)) :
                       (count_w == '0);
   wire near_full_w = (full_th_w == 2'b00) ? (count_w >= CW'(`IP_AF_LVL0)) :
                      (full_th_w == 2'b01) ? (count_w >= CW'(`IP_AF_LVL1)) :
                      (full_th_w == 2'b10) ? (count_w >= CW'(`IP_AF_LVL2)) :
                      (count_w >= CW'(`IP_AF_LVL3));
   wire filled_w = (count_w >= CW'(`IP_FILLED_LVL));
   // Back-pressure means nothing is lost; this shows a source held off by a full FIFO
   wire overflow_w = (take_text_w || take_vid_w) && !fifo_wr_ready_w;

   // ---------------------------------------------------------------
   // Reference and general-purpose pins
   // ---------------------------------------------------------------
   logic hgate_prev_reg;
   logic hext_prev_reg;
   logic vgate_prev_reg;
   logic vref_prev_reg;
   logic qual_reg;
   logic href_reg;
   logic vref_reg;
   logic gpa_reg;
   logic gpb_reg;

   wire hext_w = scaler_window_i ? line_gate_i : in_href_i;
   wire hgate_rise_w = line_gate_i && !hgate_prev_reg;
   wire hext_rise_w = hext_w && !hext_prev_reg;
   wire vgate_rise_w = vert_gate_i && !vgate_prev_reg;
   wire vref_rise_w = in_vref_i && !vref_prev_reg;

   wire href_sel_w = (hsel_w == image_port_pkg::REF_GATE) ? line_gate_i :
                     (hsel_w == image_port_pkg::REF_ALT) ? hext_w :
                     (hsel_w == image_port_pkg::REF_PULSE) ? hgate_rise_w :
                     hext_rise_w;
   wire vref_sel_w = (vsel_w == image_port_pkg::REF_GATE) ? vert_gate_i :
                     (vsel_w == image_port_pkg::REF_ALT) ? in_vref_i :
                     (vsel_w == image_port_pkg::REF_PULSE) ? vgate_rise_w :
                     vref_rise_w;

   wire qual_next = pclk_rise_w ? pop_w : qual_reg;
   wire text_flag_w = qual_reg && fifo_rd_data_w[FW-1];
   wire [7:0] gp_src_w = {near_empty_w, near_full_w, overflow_w, filled_w,
                          1'b0, text_flag_w, task_flag_i, field_id_i};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hgate_prev_reg <= 1'b0;
         hext_prev_reg <= 1'b0;
         vgate_prev_reg <= 1'b0;
         vref_prev_reg <= 1'b0;
         qual_reg <= 1'b0;
         href_reg <= 1'b0;
         vref_reg <= 1'b0;
         gpa_reg <= 1'b0;
         gpb_reg <= 1'b0;
      end else begin
         hgate_prev_reg <= line_gate_i;
         hext_prev_reg <= hext_w;
         vgate_prev_reg <= vert_gate_i;
         vref_prev_reg <= in_vref_i;
         qual_reg <= qual_next;
         href_reg <= href_sel_w ^ swap_pol_reg[`IP_HREF_POL_BIT];
         vref_reg <= vref_sel_w ^ swap_pol_reg[`IP_VREF_POL_BIT];
         gpa_reg <= gp_pick(gpa_sel_w, gp_src_w) ^ swap_pol_reg[`IP_GPA_POL_BIT];
         gpb_reg <= gp_pick(gpb_sel_w, gp_src_w) ^ swap_pol_reg[`IP_GPB_POL_BIT];
      end
   end

   // Polarity applied at the pin so a change shows without waiting for a port clock
   assign data_qualifier_out_o = qual_reg ^ swap_pol_reg[`IP_QUAL_POL_BIT];
   assign horiz_ref_out_o = href_reg;
   assign vert_ref_out_o = vref_reg;
   assign gp_out_a_o = gpa_reg;
   assign gp_out_b_o = gpb_reg;
endmodule // image_port
`default_nettype wire

// ==== design/image_port_map.svh ====
// Register offsets, field positions, reset values and levels of the image port block
`ifndef IMAGE_PORT_MAP_SVH
`define IMAGE_PORT_MAP_SVH

// ---------------------------------------------------------------
// Register offsets (subaddresses)
// ---------------------------------------------------------------
`define IP_REF_SEL_ADDR 8'h84
`define IP_SWAP_POL_ADDR 8'h85
`define IP_FIFO_ARB_ADDR 8'h86

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define IP_REF_SEL_RST 8'h00
`define IP_SWAP_POL_RST 8'h00
`define IP_FIFO_ARB_RST 8'h00
`define IP_UNMAPPED_RD 8'h00

// ---------------------------------------------------------------
// Fields of the reference select register
// ---------------------------------------------------------------
`define IP_HSEL_LSB 0
`define IP_HSEL_MSB 1
`define IP_VSEL_LSB 2
`define IP_VSEL_MSB 3
`define IP_GPB_SEL_LSB 4
`define IP_GPB_SEL_MSB 5
`define IP_GPA_SEL_LSB 6
`define IP_GPA_SEL_MSB 7

// ---------------------------------------------------------------
// Fields of the swap, limit and polarity register
// ---------------------------------------------------------------
`define IP_QUAL_POL_BIT 0
`define IP_HREF_POL_BIT 1
`define IP_VREF_POL_BIT 2
`define IP_GPB_POL_BIT 3
`define IP_GPA_POL_BIT 4
`define IP_LIMIT_BIT 5
`define IP_SWAP_LSB 6
`define IP_SWAP_MSB 7

// ---------------------------------------------------------------
// Fields of the FIFO flag and arbitration register
// ---------------------------------------------------------------
`define IP_EMPTY_TH_LSB 0
`define IP_EMPTY_TH_MSB 1
`define IP_FULL_TH_LSB 2
`define IP_FULL_TH_MSB 3
`define IP_GPB_EXT_BIT 4
`define IP_GPA_EXT_BIT 5
`define IP_ARB_LSB 6
`define IP_ARB_MSB 7

// ---------------------------------------------------------------
// Value limits and FIFO levels in double words
// ---------------------------------------------------------------
`define IP_LIM_LO_WIDE 8'h01
`define IP_LIM_HI_WIDE 8'hfe
`define IP_LIM_LO_NARROW 8'h08
`define IP_LIM_HI_NARROW 8'hf7
`define IP_AE_LVL0 16
`define IP_AE_LVL1 8
`define IP_AE_LVL2 4
`define IP_AF_LVL0 16
`define IP_AF_LVL1 24
`define IP_AF_LVL2 28
`define IP_AF_LVL3 32
`define IP_FILLED_LVL 30
`define IP_FIFO_DEPTH 32

`endif

// ==== design/image_port_pkg.sv ====
// Types shared by the image port block
`default_nettype none
package image_port_pkg;

   // ---------------------------------------------------------------
   // Modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ARB_INHIBIT = 2'b00,
      ARB_VIDEO   = 2'b01,
      ARB_TEXT    = 2'b10,
      ARB_BOTH    = 2'b11
   } arb_mode_e;

   typedef enum logic [1:0] {
      REF_GATE      = 2'b00,
      REF_ALT       = 2'b01,
      REF_PULSE     = 2'b10,
      REF_ALT_PULSE = 2'b11
   } ref_mode_e;

   typedef enum logic [2:0] {
      GP_FIELD_ID   = 3'b000,
      GP_TASK_FLAG  = 3'b001,
      GP_TEXT_FLAG  = 3'b010,
      GP_ZERO       = 3'b011,
      GP_FILLED     = 3'b100,
      GP_OVERFLOW   = 3'b101,
      GP_NEAR_FULL  = 3'b110,
      GP_NEAR_EMPTY = 3'b111
   } gp_sel_e;

endpackage
`default_nettype wire

// ==== design/README_unused.sv ====
// Intentionally empty compilation unit
`default_nettype none
`default_nettype wire

// ==== design/word_fifo.sv ====
// Synchronous FIFO with registered read data and fill count
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   input wire logic [WIDTH-1:0] wr_data_i,
   // Drain side; popped word shows on rd_data_o one cycle later
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [WIDTH-1:0] rd_data_o,
   // Fill level
   output logic [$clog2(DEPTH+1)-1:0] count_o
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("word_fifo: DEPTH must be a power of two and WIDTH positive");
      end
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic [WIDTH-1:0] rd_data_reg;
   wire push_w = wr_valid_i && wr_ready_o;
   wire pop_w = rd_valid_o && rd_ready_i;

   assign wr_ready_o = (count_reg != CW'(DEPTH));
   assign rd_valid_o = (count_reg != '0);
   assign rd_data_o = rd_data_reg;
   assign count_o = count_reg;

   // ---------------------------------------------------------------
   // Storage; no reset so it maps onto plain RAM
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (push_w) begin
         mem_reg[wr_ptr_reg] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         rd_data_reg <= '0;
      end else begin
         if (push_w) begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         end
         if (pop_w) begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
            rd_data_reg <= mem_reg[rd_ptr_reg];
         end
         if (push_w && !pop_w) begin
            count_reg <= count_reg + CW'(1);
         end else if (pop_w && !push_w) begin
            count_reg <= count_reg - CW'(1);
         end
      end
   end
endmodule // word_fifo
`default_nettype wire

// ==== dv/image_port_properties.sv ====
// Concurrent checks on the image port pins
`timescale 1ns/1ps
`default_nettype none
module image_port_properties (
   // Clock, reset and register port
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   input wire logic [7:0] reg_rdata_o,
   // Timing, streams and pins
   input wire logic line_gate_i,
   input wire logic vert_gate_i,
   input wire logic in_vref_i,
   input wire logic vid_ready_o,
   input wire logic text_valid_i,
   input wire logic text_ready_o,
   input wire logic horiz_ref_out_o,
   input wire logic vert_ref_out_o
);
   // ---------------------------------------------------------------
   // Shadow of the configuration, rebuilt from the writes seen
   // ---------------------------------------------------------------
   logic [7:0] sel_reg;
   logic [7:0] pol_reg;
   logic [7:0] arb_reg;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_reg <= 8'h00;
         pol_reg <= 8'h00;
         arb_reg <= 8'h00;
      end else if (reg_we_i) begin
         if (reg_addr_i == 8'h84) sel_reg <= reg_wdata_i;
         if (reg_addr_i == 8'h85) pol_reg <= reg_wdata_i;
         if (reg_addr_i == 8'h86) arb_reg <= reg_wdata_i;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_unmapped_read_zero: assert property (
      reg_re_i && (reg_addr_i < 8'h84 || reg_addr_i > 8'h86) |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_write_read_back: assert property (
      (reg_we_i && reg_addr_i == 8'h85) ##1 (reg_re_i && !reg_we_i && reg_addr_i == 8'h85)
      |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("read back differs");
   a_inhibit_stalls_all: assert property (
      arb_reg[7:6] == 2'b00 |-> !vid_ready_o && !text_ready_o) else $error("inhibit leaks");
   a_video_only_mode: assert property (
      arb_reg[7:6] == 2'b01 |-> !text_ready_o) else $error("text taken in video mode");
   a_text_only_mode: assert property (
      arb_reg[7:6] == 2'b10 |-> !vid_ready_o) else $error("video taken in text mode");
   a_text_goes_first: assert property (
      arb_reg[7:6] == 2'b11 && text_valid_i |-> !vid_ready_o) else $error("video beat text");
   a_href_gate_level: assert property (
      sel_reg[1:0] == 2'b00 |=> horiz_ref_out_o == $past(line_gate_i ^ pol_reg[1]))
      else $error("horizontal gate wrong");
   a_href_rise_pulse: assert property (
      sel_reg[1:0] == 2'b10 && $rose(line_gate_i)
      |=> (horiz_ref_out_o != pol_reg[1]) ##1 (horiz_ref_out_o == pol_reg[1]))
      else $error("horizontal pulse wrong");
   a_vref_input_copy: assert property (
      sel_reg[3:2] == 2'b01 |=> vert_ref_out_o == $past(in_vref_i ^ pol_reg[2]))
      else $error("vertical reference wrong");
   a_vref_gate_pulse: assert property (
      sel_reg[3:2] == 2'b10 && $rose(vert_gate_i)
      |=> (vert_ref_out_o != pol_reg[2]) ##1 (vert_ref_out_o == pol_reg[2]))
      else $error("vertical pulse wrong");
endmodule // image_port_properties
bind image_port image_port_properties u_props (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
   .reg_we_i, .reg_re_i, .reg_rdata_o, .line_gate_i, .vert_gate_i, .in_vref_i, .vid_ready_o,
   .text_valid_i, .text_ready_o, .horiz_ref_out_o, .vert_ref_out_o);
`default_nettype wire

// ==== dv/image_port_tb.sv ====
// Self-checking bench of the image port block
`timescale 1ns/1ps
`default_nettype none
module image_port_tb;
   typedef struct {logic [7:0] pol; logic code; logic [31:0] din; logic [31:0] dout;} row_s;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_we_i = 1'b0;
   logic reg_re_i = 1'b0;
   logic [7:0] tcnt = 8'h00;
   logic field_id_i = 1'b1;
   logic task_flag_i = 1'b0;
   logic vid_valid_i = 1'b0;
   logic vid_code_i = 1'b0;
   logic text_valid_i = 1'b0;
   logic [31:0] vid_data_i = 32'h0;
   logic [31:0] text_data_i = 32'h0;
   logic run = 1'b0;
   logic port_clk_i;
   logic [7:0] reg_rdata_o;
   logic [31:0] port_data_o;
   logic vid_ready_o, text_ready_o, data_qualifier_out_o;
   logic horiz_ref_out_o, vert_ref_out_o, gp_out_a_o, gp_out_b_o;
   logic [31:0] d;
   logic e;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   row_s rows[8] = '{
      '{8'h00, 1'b0, 32'h00ff8010, 32'h01fe8010},
      '{8'h20, 1'b0, 32'h00ff0809, 32'h08f70809},
      '{8'h40, 1'b0, 32'h11223344, 32'h22114433},
      '{8'h80, 1'b0, 32'h11223344, 32'h33441122},
      '{8'hc0, 1'b0, 32'h11223344, 32'h44332211},
      '{8'he0, 1'b0, 32'h00ff1020, 32'h2010f708},
      '{8'h20, 1'b1, 32'hff000080, 32'hff000080},
      '{8'hc0, 1'b1, 32'hff000080, 32'h800000ff}};
   image_port #(.DEPTH(32)) u_dut (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
      .reg_re_i, .reg_rdata_o, .line_gate_i(tcnt[2]), .scaler_window_i(tcnt[5]),
      .in_href_i(tcnt[1]), .vert_gate_i(tcnt[3]), .in_vref_i(tcnt[4]), .field_id_i,
      .task_flag_i, .vid_valid_i, .vid_ready_o, .vid_data_i, .vid_code_i, .text_valid_i,
      .text_ready_o, .text_data_i, .port_clk_i, .port_data_o, .data_qualifier_out_o,
      .horiz_ref_out_o, .vert_ref_out_o, .gp_out_a_o, .gp_out_b_o);
   port_receiver u_rx (.run_i(run), .port_clk_o(port_clk_i));
   // ---------------------------------------------------------------
   // Clock, timing patterns, watchdog
   // ---------------------------------------------------------------
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      tcnt <= tcnt + 8'h01;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         $display("MISMATCH %s expected %h seen %h", n, x, g);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_we_i <= 1'b1;
      @(posedge clk_i);
      reg_we_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
      #1;
      v = {24'h0, reg_rdata_o};
   endtask
   // Holds valid and data until the edge that sees ready high
   task automatic push(input logic t, input logic c, input logic [31:0] v);
      int n;
      n = 0;
      if (t) text_valid_i <= 1'b1;
      else vid_valid_i <= 1'b1;
      text_data_i <= v;
      vid_data_i <= v;
      vid_code_i <= c;
      #1;
      while ((t ? text_ready_o : vid_ready_o) !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n == 50) error_cnt++;
      @(posedge clk_i);
      text_valid_i <= 1'b0;
      vid_valid_i <= 1'b0;
   endtask
   // One port clock rise, then the sync latency
   task automatic pop(input logic q, input logic [31:0] v);
      run <= 1'b1;
      @(posedge port_clk_i);
      run <= 1'b0;
      repeat (6) @(posedge clk_i);
      #1;
      chk("qualifier", 32'(q), 32'(data_qualifier_out_o));
      if (q) chk("port_data", v, port_data_o);
   endtask
   task automatic summarize();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = 8'h84; a <= 8'h87; a++) begin
         rd(a[7:0], d);
         chk("reset value", 32'h0, d);
      end
      wr(8'h87, 8'ha5);
      rd(8'h87, d);
      chk("unmapped", 32'h0, d);
      wr(8'h85, 8'h5a);
      rd(8'h85, d);
      chk("read back", 32'h5a, d);
      $display("test registers done");
      wr(8'h84, 8'h00);
      wr(8'h86, 8'h40);
      foreach (rows[i]) begin
         wr(8'h85, rows[i].pol);
         push(1'b0, rows[i].code, rows[i].din);
         pop(1'b1, rows[i].dout);
      end
      $display("test rows done");
      wr(8'h85, 8'h01);
      #1;
      chk("qual inverted", 32'h0, 32'(data_qualifier_out_o));
      wr(8'h85, 8'h00);
      #1;
      chk("qual normal", 32'h1, 32'(data_qualifier_out_o));
      wr(8'h86, 8'h00);
      vid_valid_i <= 1'b1;
      text_valid_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      chk("inhibit", 32'h0, {vid_ready_o, text_ready_o});
      vid_valid_i <= 1'b0;
      text_valid_i <= 1'b0;
      @(posedge clk_i);
      wr(8'h86, 8'h80);
      push(1'b1, 1'b0, 32'h00ff0000);
      pop(1'b1, 32'h00ff0000);
      wr(8'h86, 8'hc0);
      vid_valid_i <= 1'b1;
      text_valid_i <= 1'b1;
      vid_data_i <= 32'h20202020;
      text_data_i <= 32'h30303030;
      @(posedge clk_i);
      text_valid_i <= 1'b0;
      @(posedge clk_i);
      vid_valid_i <= 1'b0;
      pop(1'b1, 32'h30303030);
      pop(1'b1, 32'h20202020);
      $display("test arbitration done");
      wr(8'h84, 8'h05);
      #1;
      e = tcnt[5] ? tcnt[2] : tcnt[1];
      repeat (40) begin
         @(posedge clk_i);
         #1;
         chk("href alt", 32'(e), 32'(horiz_ref_out_o));
         e = tcnt[5] ? tcnt[2] : tcnt[1];
      end
      wr(8'h84, 8'h0a);
      repeat (40) @(posedge clk_i);
      wr(8'h84, 8'h0f);
      repeat (40) @(posedge clk_i);
      wr(8'h85, 8'h06);
      wr(8'h84, 8'h04);
      repeat (40) @(posedge clk_i);
      $display("test references done");
      wr(8'h86, 8'h40);
      for (int i = 0; i < 6; i++) begin
         d = (i % 3 == 2) ? 32'h3 : 32'(i % 3);
         wr(8'h84, {d[1:0], d[1:0], 4'h0});
         wr(8'h85, (i < 3) ? 8'h00 : 8'h18);
         repeat (2) @(posedge clk_i);
         #1;
         e = ((i % 3 == 0) ? 1'b1 : 1'b0) ^ (i >= 3);
         chk("gp_a", 32'(e), 32'(gp_out_a_o));
         chk("gp_b", 32'(e), 32'(gp_out_b_o));
      end
      $display("test general outputs done");
      wr(8'h84, 8'he0);
      wr(8'h85, 8'h00);
      for (int k = 0; k <= 32; k++) begin
         for (int c = 0; c < 4; c++) begin
            wr(8'h86, 8'h70 | 8'(c * 5));
            repeat (3) @(posedge clk_i);
            #1;
            e = (c == 0) ? k < 16 : (c == 1) ? k < 8 : (c == 2) ? k < 4 : k == 0;
            chk("near_empty", 32'(e), 32'(gp_out_a_o));
            e = k >= ((c == 0) ? 16 : (c == 1) ? 24 : (c == 2) ? 28 : 32);
            chk("near_full", 32'(e), 32'(gp_out_b_o));
         end
         if (k < 32) push(1'b0, 1'b0, {24'h102030, 8'(k + 16)});
      end
      vid_valid_i <= 1'b1;
      #1 chk("full stall", 32'h0, 32'(vid_ready_o));
      @(posedge clk_i) vid_valid_i <= 1'b0;
      for (int k = 0; k < 32; k++) begin
         pop(1'b1, {24'h102030, 8'(k + 16)});
      end
      pop(1'b0, 32'h0);
      $display("test fill and drain done");
      summarize();
   end
endmodule // image_port_tb
`default_nettype wire

// ==== dv/port_receiver.sv ====
// Model of the receiving controller: supplies the image port clock
`timescale 1ns/1ps
`default_nettype none
module port_receiver (
   // Burst control from the bench
   input wire logic run_i,
   // Port clock towards the device
   output logic port_clk_o
);
   // ---------------------------------------------------------------
   // Port clock, 200 ns period
   // ---------------------------------------------------------------
   initial port_clk_o = 1'b0;
   // Stands still low between bursts; a burst always ends on a full period
   always begin
      #100;
      if (run_i || port_clk_o) begin
         port_clk_o = ~port_clk_o;
      end
   end
endmodule // port_receiver
`default_nettype wire
